// ### include/sus_cfg_pkg.sv
/*
  constants for the suspend/resume and read configuration command block.
  assumes a single 200 mhz clock and a synchronous active-high reset.
*/
package sus_cfg_pkg;
    localparam logic [7:0]  CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0]  CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0]  CMD_PROG_SETUP   = 8'h40;
    localparam logic [7:0]  CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0]  CMD_RESUME       = 8'hd0;
    localparam logic [7:0]  CMD_CFG_SETUP    = 8'h60;
    localparam logic [7:0]  CMD_CFG_CONFIRM  = 8'h03;
    localparam logic [15:0] CFG_RESET        = 16'h8000;
    localparam int          CFG_MODE_BIT     = 15;
    localparam int          CFG_LAT_HI       = 13;
    localparam int          CFG_LAT_LO       = 11;
    localparam int          CFG_HOLD_BIT     = 9;
    localparam int          CFG_WAIT_BIT     = 8;
    localparam int          CFG_ORDER_BIT    = 7;
    localparam int          CFG_EDGE_BIT     = 6;
    localparam int          CFG_LEN_HI       = 2;
    localparam logic [2:0]  LEN_FOUR         = 3'h1;
    localparam logic [2:0]  LEN_EIGHT        = 3'h2;
    localparam logic [2:0]  LEN_CONT         = 3'h7;
    localparam logic [2:0]  LAT_RESERVED     = 3'h1;
    localparam int          STAT_READY_BIT   = 7;
    localparam int          STAT_PSUS_BIT    = 2;
    localparam int          SUSPEND_LAT_NS   = 5000;
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          SUSPEND_LAT_CYC  = SUSPEND_LAT_NS / CLK_PERIOD_NS;
    localparam int          PROG_TIME_CYC    = 64;
    typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_SINGLE} read_sel_t;
    typedef enum logic [1:0] {W_IDLE, W_PROG, W_SUSPENDING, W_SUSPENDED} wsm_state_t;
endpackage

// ### core/sus_cfg_core.sv
/*
  command interpreter: program suspend/resume and read configuration load.
  assumes command strobes are already synchronous to clk and one cycle wide.
*/
//
// Contract
// - suspend halts programming after latency, reads status
// - suspended sets ready and suspended flags
// - suspended accepts only read array, status, resume
// - read array in suspend serves other blocks
// - resume clears flags, continues, reads status
// - chip disable in suspend keeps state
// - bit15 selects burst or page, page default
// - bits13-11 latency code, 001 reserved
// - bit9 holds data one or two clocks
// - bit8 sets wait timing
// - bit7 interleaved or linear order
// - bit6 falling or rising clock edge
// - page mode length always four words
// - read mode applies to main blocks only
// - config load is 60h plus confirm
// - config captured on first strobe rise; code captures cmd_addr on the confirm write
// - config load ignores vpp, returns read array
// - suspend b0h, resume d0h, any address
// - ready flag one ready, zero busy
// - ffh selects read array
`timescale 1ns/100ps
module sus_cfg_core
    import sus_cfg_pkg::*;
#(
    parameter int SUSPEND_CYC = SUSPEND_LAT_CYC,
    parameter int PROG_CYC    = PROG_TIME_CYC
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_data,
    input  wire logic [15:0] cmd_addr,
    input  wire logic        chip_en,
    input  wire logic        main_block,
    output logic [7:0]       status,
    output read_sel_t        read_sel,
    output logic             prog_busy,
    output logic             standby,
    output logic             read_mode_select,
    output logic [2:0]       latency_code,
    output logic             data_hold_select,
    output logic             wait_timing_select,
    output logic             burst_order_select,
    output logic             clock_edge_select,
    output logic [2:0]       burst_length_field,
    output logic             page_read,
    output logic [3:0]       burst_words,
    output logic [1:0]       hold_clocks,
    output logic             wait_early
);
    typedef struct packed {
        wsm_state_t  write_state_machine;
        read_sel_t   rsel;
        logic        cfg_pend;
        logic [15:0] cfg;
        logic [15:0] cnt;
        logic [15:0] prog_left;
    } st_t;
    st_t st_r, st_nxt;
    logic suspended;
    assign suspended = (st_r.write_state_machine == W_SUSPENDED);
    always_comb
    begin
        st_nxt = st_r;
        case (st_r.write_state_machine)
            W_PROG:
            begin
                if (st_r.prog_left == 16'h0)
                    st_nxt.write_state_machine = W_IDLE;
                else
                    st_nxt.prog_left = st_r.prog_left - 16'h1;
            end
            W_SUSPENDING:
            begin
                if (st_r.cnt == 16'h0)
                    st_nxt.write_state_machine = W_SUSPENDED;
                else
                    st_nxt.cnt = st_r.cnt - 16'h1;
            end
            default: ;
        endcase
        if (cmd_wr)
        begin
            if (st_r.cfg_pend)
            begin
                st_nxt.cfg_pend = 1'b0;
                if (cmd_data == CMD_CFG_CONFIRM)
                begin
                    st_nxt.cfg  = cmd_addr;
                    st_nxt.rsel = RD_ARRAY;
                end
            end
            else if (suspended)
            begin
                case (cmd_data)
                    CMD_READ_ARRAY:  st_nxt.rsel = RD_ARRAY;
                    CMD_READ_STATUS: st_nxt.rsel = RD_STATUS;
                    CMD_RESUME:
                    begin
                        st_nxt.write_state_machine  = W_PROG;
                        st_nxt.rsel = RD_STATUS;
                    end
                    default: ;
                endcase
            end
            else
            begin
                case (cmd_data)
                    CMD_READ_ARRAY:  st_nxt.rsel = RD_ARRAY;
                    CMD_READ_STATUS: st_nxt.rsel = RD_STATUS;
                    CMD_CFG_SETUP:   st_nxt.cfg_pend = 1'b1;
                    CMD_PROG_SETUP:
                    begin
                        if (st_r.write_state_machine == W_IDLE)
                        begin
                            st_nxt.write_state_machine       = W_PROG;
                            st_nxt.prog_left = 16'(PROG_CYC);
                            st_nxt.rsel      = RD_STATUS;
                        end
                    end
                    CMD_SUSPEND:
                    begin
                        st_nxt.rsel = RD_STATUS;
                        if (st_r.write_state_machine == W_PROG)
                        begin
                            st_nxt.write_state_machine = W_SUSPENDING;
                            st_nxt.cnt = 16'(SUSPEND_CYC - 1);
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r.write_state_machine       <= W_IDLE;
            st_r.rsel      <= RD_ARRAY;
            st_r.cfg_pend  <= 1'b0;
            st_r.cfg       <= CFG_RESET;
            st_r.cnt       <= 16'h0;
            st_r.prog_left <= 16'h0;
        end
        else
            st_r <= st_nxt;
    end
    always_comb
    begin
        status = 8'h00;
        status[STAT_READY_BIT] = (st_r.write_state_machine == W_IDLE) || suspended;
        status[STAT_PSUS_BIT]  = suspended;
    end
    assign read_sel  = (st_r.rsel == RD_ARRAY && !main_block) ? RD_SINGLE
                                                               : st_r.rsel;
    assign prog_busy = (st_r.write_state_machine == W_PROG) || (st_r.write_state_machine == W_SUSPENDING);
    assign standby   = !chip_en;
    assign read_mode_select   = st_r.cfg[CFG_MODE_BIT];
    assign latency_code       = st_r.cfg[CFG_LAT_HI:CFG_LAT_LO];
    assign data_hold_select   = st_r.cfg[CFG_HOLD_BIT];
    assign wait_timing_select = st_r.cfg[CFG_WAIT_BIT];
    assign burst_order_select = st_r.cfg[CFG_ORDER_BIT];
    assign clock_edge_select  = st_r.cfg[CFG_EDGE_BIT];
    assign burst_length_field = st_r.cfg[CFG_LEN_HI:0];
    assign page_read   = st_r.cfg[CFG_MODE_BIT] && main_block && st_r.rsel == RD_ARRAY;
    assign hold_clocks = st_r.cfg[CFG_HOLD_BIT] ? 2'h2 : 2'h1;
    assign wait_early  = st_r.cfg[CFG_WAIT_BIT];
    always_comb
    begin
        if (st_r.cfg[CFG_MODE_BIT])
            burst_words = 4'h4;
        else
            case (st_r.cfg[CFG_LEN_HI:0])
                LEN_FOUR:  burst_words = 4'h4;
                LEN_EIGHT: burst_words = 4'h8;
                LEN_CONT:  burst_words = 4'h0;
                default:   burst_words = 4'h4;
            endcase
    end

    a_suspend_lat: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.write_state_machine == W_PROG && cmd_wr && cmd_data == CMD_SUSPEND && !st_r.cfg_pend)
        |=> !status[STAT_PSUS_BIT] ##[1:1000] status[STAT_PSUS_BIT])
        else $error("suspend did not take effect");
    a_flags_pair: assert property (@(posedge clk) disable iff (sys_rst)
        status[STAT_PSUS_BIT] |-> status[STAT_READY_BIT])
        else $error("suspended flag without ready flag");
    a_only_three: assert property (@(posedge clk) disable iff (sys_rst)
        (suspended && cmd_wr && !st_r.cfg_pend && cmd_data == CMD_CFG_SETUP)
        |=> !st_r.cfg_pend)
        else $error("illegal command taken in suspend");
    a_resume_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (suspended && cmd_wr && cmd_data == CMD_RESUME)
        |=> !status[STAT_READY_BIT] && !status[STAT_PSUS_BIT] && st_r.rsel == RD_STATUS)
        else $error("resume did not clear flags");
    a_standby_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (suspended && !chip_en && !cmd_wr) |=> suspended)
        else $error("suspend lost in standby");
    a_cfg_load: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.cfg_pend && cmd_wr && cmd_data == CMD_CFG_CONFIRM)
        |=> st_r.cfg == $past(cmd_addr) && st_r.rsel == RD_ARRAY)
        else $error("configuration not loaded");
    a_idle_suspend: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.write_state_machine == W_IDLE && cmd_wr && cmd_data == CMD_SUSPEND && !st_r.cfg_pend)
        |=> st_r.write_state_machine == W_IDLE && st_r.rsel == RD_STATUS)
        else $error("idle suspend changed state");
    a_page_four: assert property (@(posedge clk) disable iff (sys_rst)
        read_mode_select |-> burst_words == 4'h4)
        else $error("page length not four");

    // status flags, suspend and standby
    a_busy_flag: assert property (@(posedge clk) disable iff (sys_rst)
        prog_busy
        |-> !status[STAT_READY_BIT] && !status[STAT_PSUS_BIT])
        else $error("ready flag set while busy");

    a_suspend_reads: assert property (@(posedge clk) disable iff (sys_rst)
        (!suspended && !st_r.cfg_pend && cmd_wr && cmd_data == CMD_SUSPEND)
        |=> st_r.rsel == RD_STATUS)
        else $error("suspend did not select status reads");

    a_timer_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.write_state_machine == W_SUSPENDING || suspended)
        |=> $stable(st_r.prog_left))
        else $error("program timer ran while suspended");

    a_suspend_stays: assert property (@(posedge clk) disable iff (sys_rst)
        (suspended && !(cmd_wr && cmd_data == CMD_RESUME))
        |=> suspended && status[STAT_PSUS_BIT])
        else $error("suspend left without resume");

    a_resume_timer: assert property (@(posedge clk) disable iff (sys_rst)
        (suspended && !st_r.cfg_pend && cmd_wr && cmd_data == CMD_RESUME)
        |=> st_r.write_state_machine == W_PROG && st_r.prog_left == $past(st_r.prog_left))
        else $error("resume did not continue programming");

    a_standby_pin: assert property (@(posedge clk) disable iff (sys_rst)
        !chip_en
        |-> standby)
        else $error("standby not entered on chip disable");

    // command selection
    a_status_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        (!st_r.cfg_pend && cmd_wr && cmd_data == CMD_READ_STATUS)
        |=> st_r.rsel == RD_STATUS)
        else $error("read status command not taken");

    a_array_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        (!st_r.cfg_pend && cmd_wr && cmd_data == CMD_READ_ARRAY)
        |=> st_r.rsel == RD_ARRAY)
        else $error("read array command not taken");

    a_suspend_array: assert property (@(posedge clk) disable iff (sys_rst)
        (suspended && !st_r.cfg_pend && cmd_wr && cmd_data == CMD_READ_ARRAY)
        |=> suspended && st_r.rsel == RD_ARRAY)
        else $error("array read in suspend not taken");

    a_single_read: assert property (@(posedge clk) disable iff (sys_rst)
        !main_block
        |-> read_sel != RD_ARRAY && !page_read)
        else $error("mode read outside main block");

    // configuration register
    a_cfg_cancel: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r.cfg_pend && cmd_wr && cmd_data != CMD_CFG_CONFIRM)
        |=> $stable(st_r.cfg) && !st_r.cfg_pend)
        else $error("configuration loaded without confirm");

    a_cfg_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !(st_r.cfg_pend && cmd_wr)
        |=> $stable(st_r.cfg))
        else $error("configuration changed without load");

    a_len_eight: assert property (@(posedge clk) disable iff (sys_rst)
        (!read_mode_select && burst_length_field == LEN_EIGHT)
        |-> burst_words == 4'h8)
        else $error("eight word burst length wrong");

    a_len_cont: assert property (@(posedge clk) disable iff (sys_rst)
        (!read_mode_select && burst_length_field == LEN_CONT)
        |-> burst_words == 4'h0)
        else $error("continuous burst length wrong");

    a_hold_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        data_hold_select
        |-> hold_clocks == 2'h2)
        else $error("data hold not two clocks");

    a_wait_early: assert property (@(posedge clk) disable iff (sys_rst)
        wait_timing_select
        |-> wait_early)
        else $error("early wait not selected");

endmodule

// ### verification/host_model.sv
/*
  host model: drives command writes onto the command bus.
  assumes the device samples cmd_wr on the rising clk edge.
*/
`timescale 1ns/100ps
module host_model
    import sus_cfg_pkg::*;
(
    input  wire logic        clk,
    output logic             cmd_wr,
    output logic [7:0]       cmd_data,
    output logic [15:0]      cmd_addr
);
    initial
    begin
        cmd_wr = 1'b0;
        cmd_data = 8'h00;
        cmd_addr = 16'h0000;
    end
    // one write cycle, lines flip once released
    task automatic wr(input logic [7:0] d, input logic [15:0] a);
        @(posedge clk);
        #1;
        cmd_wr = 1'b1;
        cmd_data = d;
        cmd_addr = a;
        @(posedge clk);
        #1;
        cmd_wr = 1'b0;
        cmd_data = ~d;
        cmd_addr = ~a;
    endtask
    // configuration value on the address lines in both cycles
    task automatic cfg(input logic [15:0] v);
        wr(CMD_CFG_SETUP, v);
        wr(CMD_CFG_CONFIRM, v);
    endtask
endmodule

// ### verification/tb.sv
/*
  self-checking bench for the suspend and read configuration block.
  assumes host_model drives the command bus; shortened counts.
*/
`timescale 1ns/100ps
module tb;
    import sus_cfg_pkg::*;
    logic        clk, sys_rst, cmd_wr, chip_en, main_block, prog_busy, standby;
    logic        read_mode_select, data_hold_select, wait_timing_select;
    logic        burst_order_select, clock_edge_select, page_read, wait_early;
    logic [7:0]  cmd_data, status;
    logic [15:0] cmd_addr;
    logic [2:0]  latency_code, burst_length_field;
    logic [3:0]  burst_words;
    logic [1:0]  hold_clocks;
    read_sel_t   read_sel;
    logic [23:0] rows [4];
    int          num_errors = 0;
    int          n_tests = 0;
    host_model host (.clk, .cmd_wr, .cmd_data, .cmd_addr);
    sus_cfg_core #(.SUSPEND_CYC(4), .PROG_CYC(20)) dut (.clk, .sys_rst, .cmd_wr, .cmd_data,
        .cmd_addr, .chip_en, .main_block, .status, .read_sel, .prog_busy, .standby,
        .read_mode_select, .latency_code, .data_hold_select, .wait_timing_select,
        .burst_order_select, .clock_edge_select, .burst_length_field, .page_read,
        .burst_words, .hold_clocks, .wait_early);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded poll of the status byte
    task automatic wait_status(input logic [7:0] s);
        int k;
        k = 0;
        while (status !== s && k < 40)
        begin
            step(1);
            k++;
        end
        chk(status, s);
    endtask
    task automatic finish_test();
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        sys_rst = 1'b1;
        chip_en = 1'b1;
        main_block = 1'b1;
        // config value, then page, words, hold clocks, early wait
        rows[0] = {16'h1001, 8'h22};
        rows[1] = {16'h33c2, 8'h45};
        rows[2] = {16'h1887, 8'h02};
        rows[3] = {16'ha002, 8'ha2};
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk(status, 8'h80);
        chk({read_mode_select, latency_code, data_hold_select, burst_length_field}, 16'h0080);
        chk({page_read, burst_words, hold_clocks, wait_early}, 8'ha2);
        chk(read_sel, RD_ARRAY);
        for (int i = 0; i < 4; i++)
        begin
            host.cfg(rows[i][23:8]);
            step(1);
            chk({read_mode_select, latency_code, data_hold_select, wait_timing_select,
                 burst_order_select, clock_edge_select, burst_length_field},
                {rows[i][23], rows[i][21:19], rows[i][17:14], rows[i][10:8]});
            chk({page_read, burst_words, hold_clocks, wait_early}, rows[i][7:0]);
            chk(read_sel, RD_ARRAY);
        end
        main_block = 1'b0;
        #1;
        chk(read_sel, RD_SINGLE);
        main_block = 1'b1;
        host.wr(CMD_CFG_SETUP, 16'h1001);
        host.wr(CMD_READ_ARRAY, 16'h1001);
        step(1);
        chk(read_mode_select, 1'b1);
        host.wr(CMD_SUSPEND, 16'h5a5a);
        step(1);
        chk({prog_busy, status, 6'h00, read_sel}, {1'b0, 8'h80, 6'h00, RD_STATUS});
        host.wr(CMD_READ_ARRAY, 16'h0000);
        host.wr(CMD_PROG_SETUP, 16'h0010);
        step(1);
        chk({prog_busy, status}, 16'h0100);
        host.wr(CMD_SUSPEND, 16'hffff);
        step(1);
        chk({status, 6'h00, read_sel}, {8'h00, 6'h00, RD_STATUS});
        wait_status(8'h84);
        host.wr(CMD_PROG_SETUP, 16'h0000);
        host.cfg(16'h1001);
        step(1);
        chk({status, read_mode_select}, 16'h0109);
        host.wr(CMD_READ_ARRAY, 16'h0000);
        step(1);
        chk(read_sel, RD_ARRAY);
        chip_en = 1'b0;
        step(3);
        chk({standby, status}, 16'h0184);
        chip_en = 1'b1;
        host.wr(CMD_RESUME, 16'h1234);
        step(1);
        chk({prog_busy, status, 6'h00, read_sel}, {1'b1, 8'h00, 6'h00, RD_STATUS});
        wait_status(8'h80);
        host.wr(CMD_READ_STATUS, 16'h0000);
        step(1);
        chk(read_sel, RD_STATUS);
        finish_test();
    end
endmodule
